// ==== logic/sfr_ctrl.sv ====
// Reset sequencing, write protection, write enable latch and learning pattern output.
// Assumes a 100 MHz reference clock and a serial clock of its own from the host.
`timescale 1ns/1ps
`include "sfr_defines.svh"
module sfr_ctrl
   import sfr_pkg::*;
#(
   parameter int WRITE_INHIBIT_CYCLES = `SFR_WRITE_INHIBIT_CYC,
   parameter int POWER_BUSY_CYCLES    = `SFR_POWER_BUSY_CYC,
   parameter int SOFT_RESET_CYCLES    = `SFR_SOFT_RESET_CYC,
   parameter int RESET_PULSE_CYCLES   = `SFR_RESET_PULSE_MIN_CYC
) (
   input  wire logic       ref_clk_in,
   input  wire logic       rst_in,
   input  wire logic       spi_clk_in,
   input  wire logic       cs_n_in,
   input  wire logic       reset_n_in,
   input  wire logic [3:0] data_line_in,
   output logic      [3:0] data_line_out,
   output logic      [3:0] data_line_oe_out,
   input  wire logic       hw_protect_en_in,
   input  wire logic       quad_enable_in,
   input  wire logic       pattern_out_enable_in,
   input  wire logic       qpi_mode_in,
   input  wire logic [5:0] lead_clocks_in,
   input  wire logic       op_done_in,
   output logic            cmd_valid_out,
   output logic      [7:0] cmd_code_out,
   output logic            cmd_refused_out,
   output logic            write_enable_latch_out,
   output logic            busy_out,
   output logic            write_inhibit_out
);

   if (WRITE_INHIBIT_CYCLES < 1 || WRITE_INHIBIT_CYCLES > 24'hffffff ||
       POWER_BUSY_CYCLES < 1 || POWER_BUSY_CYCLES > 24'hffffff ||
       SOFT_RESET_CYCLES < 1 || SOFT_RESET_CYCLES > 24'hffffff ||
       RESET_PULSE_CYCLES < 2 || RESET_PULSE_CYCLES > 255) begin : g_bad_param
      $error("sfr_ctrl: timing parameter out of range");
   end

   localparam logic [23:0] INH_LAST  = 24'(WRITE_INHIBIT_CYCLES - 1);
   localparam logic [23:0] PWR_LAST  = 24'(POWER_BUSY_CYCLES - 1);
   localparam logic [23:0] SOFT_LAST = 24'(SOFT_RESET_CYCLES - 1);
   localparam logic [7:0]  LOW_LAST  = 8'(RESET_PULSE_CYCLES - 1);

   sfr_ref_t   ref_r;
   sfr_ref_t   ref_nxt;
   sfr_frame_t fr_r;
   sfr_frame_t fr_nxt;
   sfr_link_t  lk_r;
   sfr_link_t  lk_nxt;
   logic       ddr_fall_r;
   logic       frame_rst;
   logic       link_rst;
   logic       evt;
   logic       prot;
   logic [7:0] op;

   // ------------------------------------------------------------ reference domain
   assign evt  = ref_r.tog_sync[1] ^ ref_r.tog_sync[2];
   // The opcode register is stable for at least two serial clocks after its toggle in quad mode, eight in single-line mode.
   assign op   = lk_r.evt_opc;
   assign prot = hw_protect_en_in & ~quad_enable_in & ~ref_r.wp_sync[1];

   always_comb begin
      ref_nxt = ref_r;
      ref_nxt.tog_sync = {ref_r.tog_sync[1:0], lk_r.tog};
      ref_nxt.wp_sync  = {ref_r.wp_sync[0], data_line_in[2]};
      ref_nxt.pin_sync = {ref_r.pin_sync[0], reset_n_in};
      ref_nxt.cmd_valid   = 1'b0;
      ref_nxt.cmd_refused = 1'b0;
      if (ref_r.inh_act) begin
         if (ref_r.inh_cnt == INH_LAST) begin
            ref_nxt.inh_act = 1'b0;
         end else begin
            ref_nxt.inh_cnt = ref_r.inh_cnt + 24'h000001;
         end
      end
      if (ref_r.pin_sync[1]) begin
         ref_nxt.low_cnt = 8'h00;
      end else if (ref_r.low_cnt != LOW_LAST) begin
         ref_nxt.low_cnt = ref_r.low_cnt + 8'h01;
      end
      if (op_done_in) begin
         ref_nxt.write_enable_latch = 1'b0;
      end
      case (ref_r.st)
         SFR_R_POR: begin
            if (ref_r.cnt == PWR_LAST) begin
               ref_nxt.st = SFR_R_READY;
            end else begin
               ref_nxt.cnt = ref_r.cnt + 24'h000001;
            end
         end
         SFR_R_HW: begin
            if (ref_r.pin_sync[1]) begin
               ref_nxt.st      = SFR_R_POR;
               ref_nxt.cnt     = 24'h000000;
               ref_nxt.inh_cnt = 24'h000000;
               ref_nxt.inh_act = 1'b1;
            end
         end
         SFR_R_SW: begin
            if (ref_r.cnt == SOFT_LAST) begin
               ref_nxt.st = SFR_R_READY;
            end else begin
               ref_nxt.cnt = ref_r.cnt + 24'h000001;
            end
         end
         SFR_R_READY: begin
            if (evt) begin
               ref_nxt.cmd_code = op;
               ref_nxt.armed    = 1'b0;
               if (op == `SFR_OP_RST && ref_r.armed) begin
                  ref_nxt.st  = SFR_R_SW;
                  ref_nxt.cnt = 24'h000000;
                  ref_nxt.write_enable_latch = 1'b0;
                  ref_nxt.cmd_valid = 1'b1;
               end else if ((sfr_is_quad(op) && hw_protect_en_in) ||
                            (sfr_is_write(op) && prot) ||
                            (sfr_is_inhibited(op) && ref_r.inh_act) ||
                            (sfr_needs_wel(op) && !ref_r.write_enable_latch)) begin
                  ref_nxt.cmd_refused = 1'b1;
               end else begin
                  ref_nxt.cmd_valid = 1'b1;
                  ref_nxt.armed     = (op == `SFR_OP_RST_ENABLE);
                  if (op == `SFR_OP_WREN) begin
                     ref_nxt.write_enable_latch = 1'b1;
                  end else if (op == `SFR_OP_WRDI) begin
                     ref_nxt.write_enable_latch = 1'b0;
                  end
               end
            end
         end
         default: begin
            ref_nxt.st = SFR_R_POR;
         end
      endcase
      // A valid pin pulse overrides every state, whatever the serial pins do.
      if (!ref_r.pin_sync[1] && ref_r.low_cnt == LOW_LAST) begin
         ref_nxt.st    = SFR_R_HW;
         ref_nxt.write_enable_latch   = 1'b0;
         ref_nxt.armed = 1'b0;
         ref_nxt.cmd_valid   = 1'b0;
         ref_nxt.cmd_refused = 1'b0;
      end
      ref_nxt.nready = (ref_nxt.st != SFR_R_READY);
      ref_nxt.abort  = (ref_nxt.st == SFR_R_HW);
   end

   always_ff @(posedge ref_clk_in or posedge rst_in) begin
      if (rst_in) begin
         ref_r          <= '0;
         ref_r.st       <= SFR_R_POR;
         ref_r.inh_act  <= 1'b1;
         ref_r.write_enable_latch      <= 1'b0;
         ref_r.tog_sync <= 3'h0;
         ref_r.wp_sync  <= 2'h3;
         ref_r.pin_sync <= 2'h3;
         ref_r.nready   <= 1'b1;
      end else begin
         ref_r <= ref_nxt;
      end
   end

   assign cmd_valid_out          = ref_r.cmd_valid;
   assign cmd_code_out           = ref_r.cmd_code;
   assign cmd_refused_out        = ref_r.cmd_refused;
   assign write_enable_latch_out = ref_r.write_enable_latch;
   assign busy_out               = ref_r.nready;
   assign write_inhibit_out      = ref_r.inh_act;

   // ------------------------------------------------------------ link domain
   // Frame logic is held while deselected or while the device is not ready.
   assign frame_rst = rst_in | cs_n_in | ref_r.nready;
   assign link_rst  = rst_in | ref_r.abort;

   always_comb begin
      logic       qpi;
      logic [7:0] shifted;
      logic       last;
      qpi     = lk_r.cfg_sync[3];
      shifted = qpi ? {fr_r.shift[3:0], data_line_in} : {fr_r.shift[6:0], data_line_in[0]};
      last    = qpi ? (fr_r.bits == 3'h1) : (fr_r.bits == 3'h7);
      fr_nxt  = fr_r;
      lk_nxt  = lk_r;
      lk_nxt.cfg_meta  = {qpi_mode_in, quad_enable_in, pattern_out_enable_in, hw_protect_en_in};
      lk_nxt.cfg_sync  = lk_r.cfg_meta;
      lk_nxt.lead_meta = lead_clocks_in;
      lk_nxt.lead_sync = lk_r.lead_meta;
      fr_nxt.oe = 1'b0;
      case (fr_r.st)
         SFR_L_OPC: begin
            fr_nxt.shift = shifted;
            fr_nxt.bits  = fr_r.bits + 3'h1;
            if (last) begin
               fr_nxt.bits    = 3'h0;
               lk_nxt.evt_opc = shifted;
               lk_nxt.tog     = ~lk_r.tog;
               if (shifted == `SFR_OP_PAT_WRITE) begin
                  fr_nxt.st = SFR_L_PAT;
               end else if (sfr_is_dlp_read(shifted) && lk_r.cfg_sync[1] &&
                            !lk_r.cfg_sync[0]) begin
                  fr_nxt.st   = SFR_L_LEAD;
                  fr_nxt.lead = lk_r.lead_sync;
               end else begin
                  fr_nxt.st = SFR_L_SKIP;
               end
            end
         end
         SFR_L_PAT: begin
            fr_nxt.shift = shifted;
            fr_nxt.bits  = fr_r.bits + 3'h1;
            if (last) begin
               lk_nxt.pat = shifted;
               fr_nxt.st  = SFR_L_SKIP;
            end
         end
         SFR_L_LEAD: begin
            if (fr_r.lead == 6'h00) begin
               fr_nxt.st = SFR_L_SKIP;
            end else begin
               fr_nxt.lead = fr_r.lead - 6'h01;
               // Each of the last four lead clocks carries two pattern bits, msb first.
               if (fr_r.lead <= {3'h0, `SFR_PAT_WINDOW}) begin
                  fr_nxt.oe     = 1'b1;
                  fr_nxt.rise_q = lk_r.pat[{fr_r.lead[1:0] - 2'h1, 1'b1}] ^ ddr_fall_r;
               end
            end
         end
         SFR_L_SKIP: begin
            fr_nxt.st = SFR_L_SKIP;
         end
         default: begin
            fr_nxt.st = SFR_L_SKIP;
         end
      endcase
   end

   always_ff @(posedge spi_clk_in or posedge frame_rst) begin
      if (frame_rst) begin
         fr_r    <= '0;
         fr_r.st <= SFR_L_OPC;
      end else begin
         fr_r <= fr_nxt;
      end
   end

   always_ff @(posedge spi_clk_in or posedge link_rst) begin
      if (link_rst) begin
         lk_r     <= '0;
         lk_r.pat <= `SFR_PATTERN_DEFAULT;
      end else begin
         lk_r <= lk_nxt;
      end
   end

   // The falling-edge half of the double-rate pair; the xor pair avoids a clock-muxed output.
   always_ff @(negedge spi_clk_in or posedge frame_rst) begin
      if (frame_rst) begin
         ddr_fall_r <= 1'b0;
      end else begin
         ddr_fall_r <= lk_r.pat[{fr_r.lead[1:0], 1'b0}] ^ fr_r.rise_q;
      end
   end

   // All four lines are driven together, only in quad double-rate windows; a deselect releases them, a clock pause holds them.
   assign data_line_out    = {4{fr_r.rise_q ^ ddr_fall_r}};
   assign data_line_oe_out = {4{fr_r.oe}};

   // ------------------------------------------------------------ checks
   sequence s_enable_taken;
      ref_r.cmd_valid && ref_r.cmd_code == `SFR_OP_RST_ENABLE;
   endsequence

   sequence s_reset_op;
      evt && op == `SFR_OP_RST && ref_r.st == SFR_R_READY && ref_r.armed;
   endsequence

   AST_SOFT_RESET_PAIR: assert property (@(posedge ref_clk_in) disable iff (rst_in)
      s_enable_taken ##[1:300] s_reset_op |=> ref_r.st == SFR_R_SW)
      else $error("reset pair did not start soft reset");

   AST_NO_CMD_BUSY: assert property (@(posedge ref_clk_in) disable iff (rst_in)
      ref_r.cmd_valid |-> $past(ref_r.st) == SFR_R_READY)
      else $error("instruction accepted while not ready");

   AST_HW_RESET_ABORT: assert property (@(posedge ref_clk_in) disable iff (rst_in)
      (!ref_r.pin_sync[1] && ref_r.low_cnt == LOW_LAST) |=> ref_r.abort && busy_out && !ref_r.write_enable_latch)
      else $error("valid reset pulse did not abort");

   AST_HW_RESET_BUSY: assert property (@(posedge ref_clk_in) disable iff (rst_in)
      (ref_r.st == SFR_R_HW && ref_r.pin_sync[1]) |=>
         ref_r.st == SFR_R_POR && ref_r.cnt == 24'h000000 && ref_r.inh_act)
      else $error("hardware reset did not enter power-up busy");

   AST_INHIBIT: assert property (@(posedge ref_clk_in) disable iff (rst_in)
      ref_r.cmd_valid |-> !(sfr_is_inhibited(ref_r.cmd_code) && $past(ref_r.inh_act)))
      else $error("write-type instruction accepted during inhibit delay");

   AST_WEL_CAUSE: assert property (@(posedge ref_clk_in) disable iff (rst_in)
      $rose(ref_r.write_enable_latch) |-> ref_r.cmd_valid && ref_r.cmd_code == `SFR_OP_WREN)
      else $error("write enable latch set without write enable");

   AST_NEEDS_WEL: assert property (@(posedge ref_clk_in) disable iff (rst_in)
      ref_r.cmd_valid && sfr_needs_wel(ref_r.cmd_code) |-> $past(ref_r.write_enable_latch))
      else $error("program or erase accepted with latch clear");

   AST_DONE_CLEARS: assert property (@(posedge ref_clk_in) disable iff (rst_in)
      op_done_in && !(evt && op == `SFR_OP_WREN) |=> !ref_r.write_enable_latch)
      else $error("completion did not clear write enable latch");

   AST_PROTECT: assert property (@(posedge ref_clk_in) disable iff (rst_in)
      ref_r.cmd_valid |-> !(sfr_is_write(ref_r.cmd_code) && $past(prot)))
      else $error("write accepted while hardware protected");

   AST_QUAD_OFF: assert property (@(posedge ref_clk_in) disable iff (rst_in)
      ref_r.cmd_valid |-> !(sfr_is_quad(ref_r.cmd_code) && $past(hw_protect_en_in)))
      else $error("quad instruction accepted while protect enabled");

   AST_PATTERN_WINDOW: assert property (@(posedge spi_clk_in) disable iff (frame_rst)
      fr_r.oe |-> fr_r.st == SFR_L_LEAD && lk_r.cfg_sync[1] && $past(fr_r.lead) <= 6'h04 &&
                  $past(fr_r.lead) != 6'h00)
      else $error("pattern driven outside last four dummy clocks");

   AST_PATTERN_LEN: assert property (@(posedge spi_clk_in) disable iff (frame_rst)
      $rose(fr_r.oe) |-> fr_r.oe[*4] ##1 !fr_r.oe)
      else $error("pattern window not four clocks");

   AST_DESELECT_QUIET: assert property (@(posedge ref_clk_in) disable iff (rst_in)
      cs_n_in |-> data_line_oe_out == 4'h0)
      else $error("lines driven while deselected");

   AST_BUSY_QUIET: assert property (@(posedge ref_clk_in) disable iff (rst_in)
      busy_out |-> data_line_oe_out == 4'h0)
      else $error("lines driven while busy");

   AST_BUSY_SILENT: assert property (@(posedge ref_clk_in) disable iff (rst_in)
      busy_out |=> !cmd_valid_out && !cmd_refused_out)
      else $error("instruction judged while busy");

   AST_QE_BYPASS: assert property (@(posedge ref_clk_in) disable iff (rst_in)
      evt && ref_r.st == SFR_R_READY && ref_r.pin_sync[1] && op == `SFR_OP_WREN &&
         quad_enable_in && !ref_r.inh_act |=> ref_r.write_enable_latch)
      else $error("protect pin acted with quad enable set");

   AST_WP_REFUSE: assert property (@(posedge ref_clk_in) disable iff (rst_in)
      evt && ref_r.st == SFR_R_READY && sfr_is_write(op) && prot |=>
         ref_r.cmd_refused || ref_r.abort)
      else $error("write not refused while protected");

   AST_PAT_RESTORE: assert property (@(posedge ref_clk_in) disable iff (rst_in)
      ref_r.abort |-> lk_r.pat == `SFR_PATTERN_DEFAULT)
      else $error("pattern not restored");

   AST_SOFT_END: assert property (@(posedge ref_clk_in) disable iff (rst_in)
      ref_r.st == SFR_R_SW && ref_r.cnt == SOFT_LAST && ref_r.pin_sync[1] |=>
         ref_r.st == SFR_R_READY)
      else $error("soft reset time wrong");

   AST_POR_END: assert property (@(posedge ref_clk_in) disable iff (rst_in)
      ref_r.st == SFR_R_POR && ref_r.cnt == PWR_LAST && ref_r.pin_sync[1] |=>
         ref_r.st == SFR_R_READY && !busy_out)
      else $error("power-up busy time wrong");

   AST_INHIBIT_END: assert property (@(posedge ref_clk_in) disable iff (rst_in)
      ref_r.inh_act && ref_r.inh_cnt == INH_LAST && ref_r.st != SFR_R_HW |=> !ref_r.inh_act)
      else $error("inhibit delay wrong");

   AST_LEAD_ENTRY: assert property (@(posedge spi_clk_in) disable iff (frame_rst)
      fr_r.st == SFR_L_LEAD |-> sfr_is_dlp_read(lk_r.evt_opc))
      else $error("lead phase for wrong opcode");

endmodule

// ==== pkg/sfr_defines.svh ====
// Constants of the serial flash reset, protection and learning pattern controller.
// Assumes a 100 MHz reference clock; timing counts round up nominal times.
`ifndef SFR_DEFINES_SVH
`define SFR_DEFINES_SVH

`define SFR_OP_WREN          8'h06
`define SFR_OP_WRDI          8'h04
`define SFR_OP_RST_ENABLE    8'h66
`define SFR_OP_RST           8'h99
`define SFR_OP_PAT_WRITE     8'h4a
`define SFR_OP_PROG_EXEC     8'h10
`define SFR_OP_BLK_ERASE     8'hd8
`define SFR_OP_BAD_BLK       8'ha1
`define SFR_OP_WR_STAT_A     8'h01
`define SFR_OP_WR_STAT_B     8'h1f
`define SFR_OP_LOAD          8'h02
`define SFR_OP_LOAD_RND      8'h84
`define SFR_OP_QLOAD         8'h32
`define SFR_OP_QLOAD_RND     8'h34
`define SFR_OP_QREAD_OUT     8'h6b
`define SFR_OP_QREAD_IO      8'heb
`define SFR_OP_QDTR_OUT      8'h6d
`define SFR_OP_QDTR_IO       8'hed
`define SFR_OP_QDTR_IO_B     8'hee

`define SFR_PATTERN_DEFAULT  8'h34
`define SFR_PAT_WINDOW       3'h4

`define SFR_REF_PERIOD_NS         10
`define SFR_RESET_PULSE_MIN_NS    1000
`define SFR_RESET_PULSE_MIN_CYC   ((`SFR_RESET_PULSE_MIN_NS + `SFR_REF_PERIOD_NS - 1) / `SFR_REF_PERIOD_NS)
`define SFR_WRITE_INHIBIT_DELAY_US 1000
`define SFR_WRITE_INHIBIT_CYC     ((`SFR_WRITE_INHIBIT_DELAY_US * 1000 + `SFR_REF_PERIOD_NS - 1) / `SFR_REF_PERIOD_NS)
`define SFR_POWER_BUSY_US         500
`define SFR_POWER_BUSY_CYC        ((`SFR_POWER_BUSY_US * 1000 + `SFR_REF_PERIOD_NS - 1) / `SFR_REF_PERIOD_NS)
`define SFR_SOFT_RESET_US         500
`define SFR_SOFT_RESET_CYC        ((`SFR_SOFT_RESET_US * 1000 + `SFR_REF_PERIOD_NS - 1) / `SFR_REF_PERIOD_NS)

`endif

// ==== pkg/sfr_pkg.sv ====
// Types and opcode classifiers of the serial flash reset and protection controller.
// Assumes sfr_defines.svh is on the include path.
`include "sfr_defines.svh"
package sfr_pkg;

   typedef enum logic [3:0] {
      SFR_L_OPC  = 4'b0001,
      SFR_L_PAT  = 4'b0010,
      SFR_L_LEAD = 4'b0100,
      SFR_L_SKIP = 4'b1000
   } sfr_lstate_t;

   typedef enum logic [3:0] {
      SFR_R_POR   = 4'b0001,
      SFR_R_HW    = 4'b0010,
      SFR_R_SW    = 4'b0100,
      SFR_R_READY = 4'b1000
   } sfr_rstate_t;

   function automatic logic sfr_is_write(input logic [7:0] op);
      return op inside {`SFR_OP_WREN, `SFR_OP_PROG_EXEC, `SFR_OP_BLK_ERASE, `SFR_OP_BAD_BLK,
                        `SFR_OP_WR_STAT_A, `SFR_OP_WR_STAT_B, `SFR_OP_LOAD, `SFR_OP_LOAD_RND,
                        `SFR_OP_QLOAD, `SFR_OP_QLOAD_RND};
   endfunction

   function automatic logic sfr_is_inhibited(input logic [7:0] op);
      return op inside {`SFR_OP_WREN, `SFR_OP_PROG_EXEC, `SFR_OP_BLK_ERASE,
                        `SFR_OP_WR_STAT_A, `SFR_OP_WR_STAT_B};
   endfunction

   function automatic logic sfr_needs_wel(input logic [7:0] op);
      return op inside {`SFR_OP_PROG_EXEC, `SFR_OP_BLK_ERASE, `SFR_OP_BAD_BLK};
   endfunction

   function automatic logic sfr_is_quad(input logic [7:0] op);
      return op inside {`SFR_OP_QLOAD, `SFR_OP_QLOAD_RND, `SFR_OP_QREAD_OUT, `SFR_OP_QREAD_IO,
                        `SFR_OP_QDTR_OUT, `SFR_OP_QDTR_IO, `SFR_OP_QDTR_IO_B};
   endfunction

   function automatic logic sfr_is_dlp_read(input logic [7:0] op);
      return op inside {`SFR_OP_QDTR_OUT, `SFR_OP_QDTR_IO, `SFR_OP_QDTR_IO_B};
   endfunction

   typedef struct packed {
      sfr_rstate_t st;
      logic [23:0] cnt;
      logic [23:0] inh_cnt;
      logic        inh_act;
      logic [7:0]  low_cnt;
      logic        write_enable_latch;
      logic        armed;
      logic [2:0]  tog_sync;
      logic [1:0]  wp_sync;
      logic [1:0]  pin_sync;
      logic        cmd_valid;
      logic        cmd_refused;
      logic [7:0]  cmd_code;
      logic        nready;
      logic        abort;
   } sfr_ref_t;

   typedef struct packed {
      sfr_lstate_t st;
      logic [7:0]  shift;
      logic [2:0]  bits;
      logic [5:0]  lead;
      logic        oe;
      logic        rise_q;
   } sfr_frame_t;

   typedef struct packed {
      logic [7:0] pat;
      logic [7:0] evt_opc;
      logic       tog;
      logic [3:0] cfg_meta;
      logic [3:0] cfg_sync;
      logic [5:0] lead_meta;
      logic [5:0] lead_sync;
   } sfr_link_t;

endpackage

// ==== verification/sfr_host_model.sv ====
// Host-side serial controller model: frames an opcode, optional payload and lead clocks.
// Assumes the bench resolves the shared data wires and feeds the device drive back here.
`timescale 1ns/1ps
module sfr_host_model (
   input  wire logic [3:0] dev_out_in,
   input  wire logic [3:0] dev_oe_in,
   input  wire logic       wp_level_in,
   output logic            spi_clk_out,
   output logic            cs_n_out,
   output logic      [3:0] host_d_out,
   output logic            host_oe_out
);
   logic [7:0] cap;
   int         ncap;
   int         nbad;

   // The clock rests low between frames, as a mode 0 host leaves it.
   initial begin
      spi_clk_out = 1'b0;
      cs_n_out = 1'b1;
      host_d_out = 4'hf;
      host_oe_out = 1'b1;
   end

   task automatic samp();
      if (dev_oe_in[0] === 1'b1) begin
         cap = {cap[6:0], dev_out_in[0]};
         ncap++;
         if (dev_out_in !== {4{dev_out_in[0]}} || dev_oe_in !== 4'hf) nbad++;
      end
   endtask

   // Data changes mid low phase, so the device takes it on the rising edge.
   task automatic tick(input logic [3:0] d);
      host_d_out = d;
      #8 spi_clk_out = 1'b1;
      #8 samp();
      #8 spi_clk_out = 1'b0;
      #8 samp();
   endtask

   // Link edges drift against the reference clock, as an unrelated clock does.
   task automatic frame(input logic [7:0] op, input logic qpi, input logic [7:0] pay,
                        input logic with_pay, input int lead);
      logic [15:0] word;
      int          nb;
      word = {op, pay};
      nb = with_pay ? 16 : 8;
      cap = 8'h00;
      ncap = 0;
      nbad = 0;
      // Two clocks while deselected carry the mode and enable settings into the link domain.
      repeat (2) tick({1'b1, wp_level_in, 2'h3});
      #3 cs_n_out = 1'b0;
      #8;
      for (int i = 15; i >= 16 - nb; i = i - (qpi ? 4 : 1))
         tick(qpi ? word[i -: 4] : {1'b1, wp_level_in, 1'b1, word[i]});
      // Released lines show the inverse of the last value, never a stale copy.
      host_oe_out = 1'b0;
      if (lead > 0) repeat (lead + 2) tick(host_d_out);
      host_oe_out = 1'b1;
      #8 cs_n_out = 1'b1;
      #40;
   endtask
endmodule

// ==== verification/tb.sv ====
// Self-checking bench of the reset, protection and learning pattern controller.
// Assumes shortened busy, inhibit and pulse counts and a host model on the serial side.
`timescale 1ns/1ps
module tb;
   import sfr_pkg::*;
   localparam int INH = 120, PWR = 40, SOFT = 60, PULSE = 10, LIMIT = 20000;
   typedef struct {logic [7:0] op; logic qpi, prot, qe, wp, done; logic [1:0] res; logic write_enable_latch;} sfr_row_t;

   logic       ref_clk_in, rst_in, reset_n_in, hw_protect_en_in, quad_enable_in, wp;
   logic       pattern_out_enable_in, qpi_mode_in, op_done_in, spi_clk, cs_n, host_oe;
   logic [5:0] lead_clocks_in;
   logic [3:0] host_d, dl_out, dl_oe, dl;
   logic       cmd_valid_out, cmd_refused_out, write_enable_latch_out, busy_out, write_inhibit_out;
   logic [7:0] cmd_code_out;
   int         n_fail, check_count, n_val, n_ref, cycles;
   // Result codes: 0 ignored, 1 accepted, 2 refused.
   sfr_row_t   rows [12] = '{
      '{8'h10,0,0,0,1,0,2,0}, '{8'h06,0,0,0,1,0,1,1}, '{8'hd8,0,0,0,1,1,1,0}, '{8'ha1,0,0,0,1,0,2,0},
      '{8'h06,1,0,0,1,0,1,1}, '{8'h04,0,0,0,1,0,1,0}, '{8'h06,0,1,0,0,0,2,0}, '{8'h06,0,1,1,0,0,1,1},
      '{8'h10,0,1,0,1,1,1,0}, '{8'h6b,0,1,0,1,0,2,0}, '{8'hed,0,1,0,1,0,2,0}, '{8'h32,0,0,0,1,0,1,0}};

   assign dl = (dl_oe & dl_out) | (~dl_oe & (host_oe ? host_d : ~host_d));

   sfr_ctrl #(.WRITE_INHIBIT_CYCLES(INH), .POWER_BUSY_CYCLES(PWR), .SOFT_RESET_CYCLES(SOFT),
              .RESET_PULSE_CYCLES(PULSE)) sfr_ctrl_i (
      .ref_clk_in(ref_clk_in), .rst_in(rst_in), .spi_clk_in(spi_clk), .cs_n_in(cs_n),
      .reset_n_in(reset_n_in), .data_line_in(dl), .data_line_out(dl_out), .data_line_oe_out(dl_oe),
      .hw_protect_en_in(hw_protect_en_in), .quad_enable_in(quad_enable_in),
      .pattern_out_enable_in(pattern_out_enable_in), .qpi_mode_in(qpi_mode_in),
      .lead_clocks_in(lead_clocks_in), .op_done_in(op_done_in), .cmd_valid_out(cmd_valid_out),
      .cmd_code_out(cmd_code_out), .cmd_refused_out(cmd_refused_out),
      .write_enable_latch_out(write_enable_latch_out), .busy_out(busy_out),
      .write_inhibit_out(write_inhibit_out));

   sfr_host_model sfr_host_model_i (.dev_out_in(dl_out), .dev_oe_in(dl_oe), .wp_level_in(wp),
      .spi_clk_out(spi_clk), .cs_n_out(cs_n), .host_d_out(host_d), .host_oe_out(host_oe));

   initial begin
      ref_clk_in = 1'b0;
      #2;
      forever #5 ref_clk_in = ~ref_clk_in;
   end

   task automatic tally_and_finish();
      $display("Comparisons %0d, mismatches %0d", check_count, n_fail);
      if (n_fail == 0 && check_count > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   always @(posedge ref_clk_in) begin
      cycles++;
      if (cmd_valid_out === 1'b1) n_val++;
      if (cmd_refused_out === 1'b1) n_ref++;
      if (cs_n === 1'b1 && dl_oe !== 4'h0) begin
         n_fail++;
         $display("MISMATCH deselected drive expected 0 seen %h", dl_oe);
      end
      if (cycles == LIMIT) begin
         n_fail++;
         tally_and_finish();
      end
   end

   task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
      check_count++;
      if (seen !== exp) begin
         n_fail++;
         $display("MISMATCH %s expected %h seen %h", name, exp, seen);
      end
   endtask

   task automatic flags(input logic b, input logic w, input logic i);
      #1;
      check("busy", {7'h0, busy_out}, {7'h0, b});
      check("wel", {7'h0, write_enable_latch_out}, {7'h0, w});
      check("inhibit", {7'h0, write_inhibit_out}, {7'h0, i});
   endtask

   task automatic judge(input logic [7:0] op, input logic qpi, input logic [1:0] res);
      int v0;
      int r0;
      v0 = n_val;
      r0 = n_ref;
      sfr_host_model_i.frame(op, qpi, 8'h00, 1'b0, 0);
      repeat (10) @(posedge ref_clk_in);
      #1;
      check("accepted", 8'(n_val - v0), {7'h0, res == 2'd1});
      check("refused", 8'(n_ref - r0), {7'h0, res == 2'd2});
      if (res != 2'd0) check("code", cmd_code_out, op);
   endtask

   task automatic read_pat(input logic [7:0] op, input logic [7:0] exp, input logic [7:0] n);
      sfr_host_model_i.frame(op, 1'b0, 8'h00, 1'b0, 6);
      check("pattern", sfr_host_model_i.cap, exp);
      check("pattern bits", 8'(sfr_host_model_i.ncap), n);
      check("line mismatch", 8'(sfr_host_model_i.nbad), 8'h00);
      repeat (8) @(posedge ref_clk_in);
   endtask

   initial begin
      rst_in <= 1'b1;
      reset_n_in <= 1'b1;
      hw_protect_en_in <= 1'b0;
      quad_enable_in <= 1'b0;
      pattern_out_enable_in <= 1'b0;
      qpi_mode_in <= 1'b0;
      op_done_in <= 1'b0;
      wp <= 1'b1;
      lead_clocks_in <= 6'h06;
      repeat (20) @(posedge ref_clk_in);
      flags(1'b1, 1'b0, 1'b1);
      check("oe in reset", {4'h0, dl_oe}, 8'h00);
      @(posedge ref_clk_in);
      rst_in <= 1'b0;
      repeat (PWR - 1) @(posedge ref_clk_in);
      flags(1'b1, 1'b0, 1'b1);
      repeat (2) @(posedge ref_clk_in);
      flags(1'b0, 1'b0, 1'b1);
      judge(8'h06, 1'b0, 2'd2);
      repeat (60) @(posedge ref_clk_in);
      flags(1'b0, 1'b0, 1'b0);
      foreach (rows[i]) begin
         @(posedge ref_clk_in);
         hw_protect_en_in <= rows[i].prot;
         quad_enable_in <= rows[i].qe;
         qpi_mode_in <= rows[i].qpi;
         wp <= rows[i].wp;
         repeat (4) @(posedge ref_clk_in);
         judge(rows[i].op, rows[i].qpi, rows[i].res);
         if (rows[i].done) begin
            @(posedge ref_clk_in);
            op_done_in <= 1'b1;
            @(posedge ref_clk_in);
            op_done_in <= 1'b0;
            repeat (2) @(posedge ref_clk_in);
         end
         check("wel", {7'h0, write_enable_latch_out}, {7'h0, rows[i].write_enable_latch});
      end
      judge(8'h66, 1'b0, 2'd1);
      judge(8'h04, 1'b0, 2'd1);
      judge(8'h99, 1'b0, 2'd1);
      check("busy", {7'h0, busy_out}, 8'h00);
      judge(8'h66, 1'b0, 2'd1);
      judge(8'h99, 1'b0, 2'd1);
      check("busy", {7'h0, busy_out}, 8'h01);
      judge(8'h06, 1'b0, 2'd0);
      repeat (20) @(posedge ref_clk_in);
      flags(1'b0, 1'b0, 1'b0);
      @(posedge ref_clk_in);
      pattern_out_enable_in <= 1'b1;
      read_pat(8'hed, 8'h34, 8'h08);
      sfr_host_model_i.frame(8'h4a, 1'b0, 8'ha5, 1'b1, 0);
      repeat (10) @(posedge ref_clk_in);
      read_pat(8'hee, 8'ha5, 8'h08);
      read_pat(8'h6b, 8'h00, 8'h00);
      pattern_out_enable_in <= 1'b0;
      read_pat(8'h6d, 8'h00, 8'h00);
      pattern_out_enable_in <= 1'b1;
      judge(8'h06, 1'b0, 2'd1);
      @(posedge ref_clk_in);
      reset_n_in <= 1'b0;
      judge(8'h06, 1'b0, 2'd0);
      flags(1'b1, 1'b0, 1'b0);
      @(posedge ref_clk_in);
      reset_n_in <= 1'b1;
      repeat (PWR - 5) @(posedge ref_clk_in);
      flags(1'b1, 1'b0, 1'b1);
      repeat (12) @(posedge ref_clk_in);
      flags(1'b0, 1'b0, 1'b1);
      read_pat(8'hed, 8'h34, 8'h08);
      tally_and_finish();
   end
endmodule
